// *** hw/pesm_pkg.sv ***
package pesm_pkg;

    // ------------------------------------------------------------
    // Widths and timing
    // ------------------------------------------------------------
    localparam int CNT_W = 32;         // Width of every long-term counter
    localparam int DIV_W = 64;         // Divider operand width
    localparam int FRAC_W = 16;        // Fraction bits of every ratio (Q16.16)
    localparam int RAT_W = 32;         // Width of a reported ratio
    localparam int LAG_S = 10;         // Availability decision lag, seconds
    localparam int SEVERE_PCT = 30;    // Errored-block share marking a severe second
    localparam int PCT_DEN = 100;      // Percent scale
    localparam int BPS_DEF = 8000;     // Default blocks per second of the path
    localparam int N_DIV = 4;          // Fraction, background, errored, severe ratios
    localparam int DIV_FRAC = 0;
    localparam int DIV_BKG = 1;
    localparam int DIV_ERR = 2;
    localparam int DIV_SEV = 3;
    localparam logic [CNT_W-1:0] CNT_RST = 32'h0000_0000;
    localparam logic [RAT_W-1:0] RAT_RST = 32'h0000_0000;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    // Classification of one finished second
    typedef struct packed {
        logic errored_second;
        logic severe_error_second;
        logic [CNT_W-1:0] background_block_error;
    } pesm_sec_t;

    // Long-term counts of the current measurement period
    typedef struct packed {
        logic [CNT_W-1:0] errored_second_count;
        logic [CNT_W-1:0] severe_second_count;
        logic [CNT_W-1:0] background_error_count;
        logic [CNT_W-1:0] unavailable_seconds;
        logic [CNT_W-1:0] period_seconds;
    } pesm_counts_t;

    // Ratios, Q16.16
    typedef struct packed {
        logic [RAT_W-1:0] background_error_ratio;
        logic [RAT_W-1:0] errored_second_ratio;
        logic [RAT_W-1:0] severe_second_ratio;
    } pesm_ratio_t;

    // Ratio evaluation sequence
    typedef enum logic [1:0] {
        RS_IDLE = 2'b00,
        RS_RUN = 2'b01,
        RS_DONE = 2'b11
    } pesm_rstate_t;

endpackage

// *** hw/pesm_div.sv ***
`timescale 1ns/100ps
// Restoring divider: one quotient bit per clock, W clocks per division.
// A zero divisor yields an all-ones quotient rather than hanging.
module pesm_div #(
    parameter int W = 64
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic start_in,
    input wire logic [W-1:0] num_in,
    input wire logic [W-1:0] den_in,
    output logic busy_out,
    output logic done_out,
    output logic [W-1:0] quo_out
);
    localparam int CW = $clog2(W + 1);

    logic [W:0] rem_r, rem_nxt;
    logic [W-1:0] quo_r, quo_nxt;
    logic [W-1:0] den_r, den_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic busy_r, busy_nxt;
    logic done_r, done_nxt;

    if (W < 2) begin : g_bad_w
        $error("pesm_div: W must be at least 2");
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [W:0] shifted;
        shifted = {rem_r[W-1:0], quo_r[W-1]};
        rem_nxt = rem_r;
        quo_nxt = quo_r;
        den_nxt = den_r;
        cnt_nxt = cnt_r;
        busy_nxt = busy_r;
        done_nxt = 1'b0;
        if (start_in && !busy_r) begin
            rem_nxt = '0;
            quo_nxt = num_in;
            den_nxt = den_in;
            cnt_nxt = CW'(W);
            busy_nxt = 1'b1;
        end else if (busy_r) begin
            if (shifted >= {1'b0, den_r}) begin
                rem_nxt = shifted - {1'b0, den_r};
                quo_nxt = {quo_r[W-2:0], 1'b1};
            end else begin
                rem_nxt = shifted;
                quo_nxt = {quo_r[W-2:0], 1'b0};
            end
            cnt_nxt = cnt_r - 1'b1;
            if (cnt_r == CW'(1)) begin
                busy_nxt = 1'b0;
                done_nxt = 1'b1;
            end
        end
    end

    // Registers
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rem_r <= '0;
            quo_r <= '0;
            den_r <= '0;
            cnt_r <= '0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            rem_r <= rem_nxt;
            quo_r <= quo_nxt;
            den_r <= den_nxt;
            cnt_r <= cnt_nxt;
            busy_r <= busy_nxt;
            done_r <= done_nxt;
        end
    end

    assign busy_out = busy_r;
    assign done_out = done_r;
    assign quo_out = quo_r;

endmodule

// *** hw/pesm_monitor.sv ***
`timescale 1ns/100ps
// Operation
// RULE1 - Decide availability with ten-second lag everywhere
// RULE2 - New period clears all event counters
// RULE3 - Count errored blocks inside each second
// RULE4 - Report errored blocks as share of blocks/second
// RULE5 - Background ratio over available non-severe blocks
// RULE6 - Errored and severe ratios over available seconds
// RULE7 - Ratios evaluable mid-period or after it
// RULE8 - Classify second before testing availability
// RULE9 - Detect errors whether available or not
// RULE10 - No counting while path unavailable
// RULE11 - Correct counts for lagged availability change
// RULE12 - Severe on thirty percent errored or defect
// RULE13 - Keep unavailable seconds, cleared each period
module pesm_monitor #(
    parameter int BPS = pesm_pkg::BPS_DEF
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic sec_tick_in,
    input wire logic period_start_in,
    input wire logic blk_valid_in,
    input wire logic blk_err_in,
    input wire logic defect_in,
    input wire logic ratio_req_in,
    output pesm_pkg::pesm_counts_t counts_out,
    output logic [pesm_pkg::CNT_W-1:0] errored_block_count_out,
    output logic [pesm_pkg::RAT_W-1:0] errored_block_fraction_out,
    output logic sec_done_out,
    output pesm_pkg::pesm_sec_t sec_class_out,
    output logic available_out,
    output pesm_pkg::pesm_ratio_t ratio_out,
    output logic ratio_valid_out,
    output logic ratio_busy_out
);
    import pesm_pkg::*;

    localparam int RUN_W = $clog2(LAG_S + 1);

    if (BPS < 1 || BPS > 32'h00ff_ffff) begin : g_bad_bps
        $error("pesm_monitor: BPS out of range");
    end

    // ------------------------------------------------------------
    // Per-second detection and classification
    // ------------------------------------------------------------
    logic [CNT_W-1:0] errblk_acc_r, errblk_acc_nxt;
    logic defect_acc_r, defect_acc_nxt;
    logic [CNT_W-1:0] errblk_last_r, errblk_last_nxt;
    logic sec_done_r, sec_done_nxt;
    pesm_sec_t sec_class_r, sec_class_nxt;
    logic [CNT_W-1:0] errblk_total;
    logic defect_total;
    logic severe_now;

    // Includes the tick cycle itself so no block at the boundary is lost
    always_comb begin
        errblk_total = errblk_acc_r + CNT_W'(blk_valid_in & blk_err_in); // [RULE3] [RULE9]
        defect_total = defect_acc_r | defect_in;
        severe_now = defect_total ||
                     (DIV_W'(errblk_total) * DIV_W'(PCT_DEN) >=
                      DIV_W'(BPS) * DIV_W'(SEVERE_PCT));                // [RULE12]
        errblk_acc_nxt = errblk_total;
        defect_acc_nxt = defect_total;
        errblk_last_nxt = errblk_last_r;
        sec_done_nxt = 1'b0;
        sec_class_nxt = sec_class_r;
        if (sec_tick_in) begin
            errblk_acc_nxt = '0;
            defect_acc_nxt = 1'b0;
            errblk_last_nxt = errblk_total;
            sec_done_nxt = 1'b1;
            sec_class_nxt.errored_second = (errblk_total != '0) || defect_total;
            sec_class_nxt.severe_error_second = severe_now;
            sec_class_nxt.background_block_error = severe_now ? '0 : errblk_total;
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            errblk_acc_r <= '0;
            defect_acc_r <= 1'b0;
            errblk_last_r <= '0;
            sec_done_r <= 1'b0;
            sec_class_r <= '0;
        end else begin
            errblk_acc_r <= errblk_acc_nxt;
            defect_acc_r <= defect_acc_nxt;
            errblk_last_r <= errblk_last_nxt;
            sec_done_r <= sec_done_nxt;
            sec_class_r <= sec_class_nxt;
        end
    end

    // ------------------------------------------------------------
    // Availability lag line and long-term counters
    // ------------------------------------------------------------
    // Seconds wait LAG_S ticks before they are counted; by then the
    // availability verdict covering them is known, which replaces
    // retrospective subtraction with a simple delay.
    pesm_sec_t lag_q_r [LAG_S];
    pesm_sec_t lag_q_nxt [LAG_S];
    logic [LAG_S-1:0] lag_vld_r, lag_vld_nxt;
    logic [RUN_W-1:0] sev_run_r, sev_run_nxt;
    logic [RUN_W-1:0] ok_run_r, ok_run_nxt;
    logic avail_r, avail_nxt;
    pesm_counts_t cnt_r, cnt_nxt;

    always_comb begin
        pesm_sec_t old;
        old = lag_q_r[LAG_S-1];
        lag_q_nxt = lag_q_r;
        lag_vld_nxt = lag_vld_r;
        sev_run_nxt = sev_run_r;
        ok_run_nxt = ok_run_r;
        avail_nxt = avail_r;
        cnt_nxt = period_start_in ? '0 : cnt_r;                           // [RULE2] [RULE13]
        if (sec_done_r) begin
            // Count the oldest second under the verdict already in force
            if (lag_vld_r[LAG_S-1]) begin
                cnt_nxt.period_seconds = cnt_nxt.period_seconds + 1'b1;
                if (!avail_r) begin
                    cnt_nxt.unavailable_seconds = cnt_nxt.unavailable_seconds + 1'b1; // [RULE13]
                end else begin                                            // [RULE10]
                    cnt_nxt.errored_second_count =
                        cnt_nxt.errored_second_count + CNT_W'(old.errored_second);
                    cnt_nxt.severe_second_count =
                        cnt_nxt.severe_second_count + CNT_W'(old.severe_error_second);
                    cnt_nxt.background_error_count =
                        cnt_nxt.background_error_count + old.background_block_error;
                end
            end
            for (int i = LAG_S - 1; i > 0; i--) begin
                lag_q_nxt[i] = lag_q_r[i-1];
            end
            lag_q_nxt[0] = sec_class_r;                                   // [RULE8]
            lag_vld_nxt = {lag_vld_r[LAG_S-2:0], 1'b1};
            // Run lengths of the newest seconds steer the verdict
            if (sec_class_r.severe_error_second) begin
                sev_run_nxt = (sev_run_r == RUN_W'(LAG_S)) ? sev_run_r : sev_run_r + 1'b1;
                ok_run_nxt = '0;
            end else begin
                ok_run_nxt = (ok_run_r == RUN_W'(LAG_S)) ? ok_run_r : ok_run_r + 1'b1;
                sev_run_nxt = '0;
            end
            // The run's seconds are still queued, so they fall on the new side
            if (avail_r && sev_run_nxt == RUN_W'(LAG_S)) begin
                avail_nxt = 1'b0;                                         // [RULE1] [RULE11]
            end else if (!avail_r && ok_run_nxt == RUN_W'(LAG_S)) begin
                avail_nxt = 1'b1;                                         // [RULE1] [RULE11]
            end
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < LAG_S; i++) begin
                lag_q_r[i] <= '0;
            end
            lag_vld_r <= '0;
            sev_run_r <= '0;
            ok_run_r <= '0;
            avail_r <= 1'b1;
            cnt_r <= '0;
        end else begin
            lag_q_r <= lag_q_nxt;
            lag_vld_r <= lag_vld_nxt;
            sev_run_r <= sev_run_nxt;
            ok_run_r <= ok_run_nxt;
            avail_r <= avail_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // ------------------------------------------------------------
    // Dividers
    // ------------------------------------------------------------
    logic [N_DIV-1:0] div_start;
    logic [N_DIV-1:0] div_busy;
    logic [N_DIV-1:0] div_done;
    logic [N_DIV-1:0][DIV_W-1:0] div_num;
    logic [N_DIV-1:0][DIV_W-1:0] div_den;
    logic [N_DIV-1:0][DIV_W-1:0] div_quo;
    logic [CNT_W-1:0] avail_secs;
    logic [CNT_W-1:0] clean_secs;
    pesm_rstate_t rs_r, rs_nxt;

    always_comb begin
        avail_secs = cnt_r.period_seconds - cnt_r.unavailable_seconds;
        clean_secs = avail_secs - cnt_r.severe_second_count;
        div_num[DIV_FRAC] = DIV_W'(errblk_last_r) << FRAC_W;
        div_den[DIV_FRAC] = DIV_W'(BPS);                                  // [RULE4]
        div_num[DIV_BKG] = DIV_W'(cnt_r.background_error_count) << FRAC_W;
        div_den[DIV_BKG] = DIV_W'(clean_secs) * DIV_W'(BPS);              // [RULE5]
        div_num[DIV_ERR] = DIV_W'(cnt_r.errored_second_count) << FRAC_W;
        div_den[DIV_ERR] = DIV_W'(avail_secs);                            // [RULE6]
        div_num[DIV_SEV] = DIV_W'(cnt_r.severe_second_count) << FRAC_W;
        div_den[DIV_SEV] = DIV_W'(avail_secs);                            // [RULE6]
        div_start[DIV_FRAC] = sec_done_r;
        div_start[DIV_BKG] = (rs_r == RS_IDLE) && ratio_req_in;
        div_start[DIV_ERR] = div_start[DIV_BKG];
        div_start[DIV_SEV] = div_start[DIV_BKG];
    end

    for (genvar g = 0; g < N_DIV; g++) begin : g_div
        pesm_div #(
            .W(DIV_W)
        ) u_div (
            .ref_clk_in(ref_clk_in),
            .rst_in(rst_in),
            .start_in(div_start[g]),
            .num_in(div_num[g]),
            .den_in(div_den[g]),
            .busy_out(div_busy[g]),
            .done_out(div_done[g]),
            .quo_out(div_quo[g])
        );
    end

    // ------------------------------------------------------------
    // Ratio evaluation, allowed at any point of a period
    // ------------------------------------------------------------
    logic [RAT_W-1:0] frac_r, frac_nxt;
    pesm_ratio_t ratio_r, ratio_nxt;
    logic ratio_valid_r, ratio_valid_nxt;

    always_comb begin
        rs_nxt = rs_r;
        ratio_nxt = ratio_r;
        ratio_valid_nxt = 1'b0;
        frac_nxt = div_done[DIV_FRAC] ? div_quo[DIV_FRAC][RAT_W-1:0] : frac_r;
        unique case (rs_r)
            RS_IDLE: begin
                if (ratio_req_in) begin
                    rs_nxt = RS_RUN;                                      // [RULE7]
                end
            end
            RS_RUN: begin
                if (div_done[DIV_BKG]) begin
                    ratio_nxt.background_error_ratio = div_quo[DIV_BKG][RAT_W-1:0];
                    ratio_nxt.errored_second_ratio = div_quo[DIV_ERR][RAT_W-1:0];
                    ratio_nxt.severe_second_ratio = div_quo[DIV_SEV][RAT_W-1:0];
                    ratio_valid_nxt = 1'b1;
                    rs_nxt = RS_DONE;
                end
            end
            RS_DONE: begin
                rs_nxt = RS_IDLE;
            end
            default: begin
                rs_nxt = RS_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rs_r <= RS_IDLE;
            frac_r <= RAT_RST;
            ratio_r <= '0;
            ratio_valid_r <= 1'b0;
        end else begin
            rs_r <= rs_nxt;
            frac_r <= frac_nxt;
            ratio_r <= ratio_nxt;
            ratio_valid_r <= ratio_valid_nxt;
        end
    end

    // Outputs
    assign counts_out = cnt_r;
    assign errored_block_count_out = errblk_last_r;
    assign errored_block_fraction_out = frac_r;
    assign sec_done_out = sec_done_r;
    assign sec_class_out = sec_class_r;
    assign available_out = avail_r;
    assign ratio_out = ratio_r;
    assign ratio_valid_out = ratio_valid_r;
    assign ratio_busy_out = (rs_r != RS_IDLE);

endmodule

// *** sim/pesm_props.sv ***
`timescale 1ns/100ps
// Port-level timing and classification checks for the monitor
module pesm_props #(
    parameter int BPS = pesm_pkg::BPS_DEF
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic sec_tick_in,
    input wire logic period_start_in,
    input wire logic blk_valid_in,
    input wire logic blk_err_in,
    input wire logic defect_in,
    input wire logic ratio_req_in,
    input wire pesm_pkg::pesm_counts_t counts_out,
    input wire logic [pesm_pkg::CNT_W-1:0] errored_block_count_out,
    input wire logic [pesm_pkg::RAT_W-1:0] errored_block_fraction_out,
    input wire logic sec_done_out,
    input wire pesm_pkg::pesm_sec_t sec_class_out,
    input wire logic available_out,
    input wire pesm_pkg::pesm_ratio_t ratio_out,
    input wire logic ratio_valid_out,
    input wire logic ratio_busy_out
);
    import pesm_pkg::*;
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (rst_in);
    logic sev;
    logic [63:0] errblk_pct;
    // Wide product so a large block count cannot wrap the threshold test
    assign sev = sec_class_out.severe_error_second;
    assign errblk_pct = 64'(errored_block_count_out) * PCT_DEN;

    chk_done_tick: assert property (sec_tick_in |=> sec_done_out)
        else $error("closed second not reported");
    chk_done_cause: assert property (sec_done_out |-> $past(sec_tick_in))
        else $error("second reported without a tick");
    chk_sev_share: assert property (sec_done_out && !sev
        |-> errblk_pct < 64'(BPS) * SEVERE_PCT) else $error("severe share missed");
    chk_sev_class: assert property (sec_done_out && sev |-> sec_class_out.errored_second
        && sec_class_out.background_block_error == 0) else $error("severe second misclassed");
    chk_bbe_count: assert property (sec_done_out && !sev |->
        sec_class_out.background_block_error == errored_block_count_out
        && (errored_block_count_out == 0 || sec_class_out.errored_second))
        else $error("background count differs");
    chk_period_clr: assert property (period_start_in && !sec_done_out
        |=> counts_out == '0) else $error("counts not cleared");
    chk_counts_hold: assert property (!$past(sec_done_out) && !$past(period_start_in)
        |-> $stable(counts_out)) else $error("counts moved between seconds");
    chk_avail_hold: assert property (!$past(sec_done_out) |-> $stable(available_out))
        else $error("availability moved between seconds");
    chk_ratio_time: assert property (ratio_req_in && !ratio_busy_out |=>
        (ratio_busy_out && !ratio_valid_out)[*8] ##58 ratio_valid_out)
        else $error("ratio latency wrong");

    cov_outage: cover property ($fell(available_out));
    cov_ratio: cover property (ratio_valid_out);
    cov_severe: cover property (sec_done_out && sev);
endmodule
bind pesm_monitor pesm_props #(.BPS(BPS)) u_props (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .sec_tick_in(sec_tick_in),
    .period_start_in(period_start_in), .blk_valid_in(blk_valid_in), .blk_err_in(blk_err_in),
    .defect_in(defect_in), .ratio_req_in(ratio_req_in), .counts_out(counts_out),
    .errored_block_count_out(errored_block_count_out),
    .errored_block_fraction_out(errored_block_fraction_out), .sec_done_out(sec_done_out),
    .sec_class_out(sec_class_out), .available_out(available_out), .ratio_out(ratio_out),
    .ratio_valid_out(ratio_valid_out), .ratio_busy_out(ratio_busy_out)
);

// *** sim/pesm_src.sv ***
`timescale 1ns/100ps
// Upstream error detector stand-in: one second of blocks, then a tick
module pesm_src #(
    parameter int SEC = 80
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic go_in,
    input wire logic [7:0] nblk_in,
    input wire logic [7:0] nerr_in,
    input wire logic def_in,
    output logic blk_valid_out,
    output logic blk_err_out,
    output logic defect_out,
    output logic sec_tick_out,
    output logic busy_out
);
    int cyc;
    // Falling-edge driver; the error flag toggles when unqualified so a stale value never helps
    always @(negedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cyc <= 0;
            busy_out <= 1'b0;
            blk_valid_out <= 1'b0;
            blk_err_out <= 1'b0;
            defect_out <= 1'b0;
            sec_tick_out <= 1'b0;
        end else begin
            blk_valid_out <= 1'b0;
            blk_err_out <= ~blk_err_out;
            defect_out <= 1'b0;
            sec_tick_out <= 1'b0;
            if (go_in && !busy_out) begin
                busy_out <= 1'b1;
                cyc <= 0;
            end else if (busy_out) begin
                cyc <= cyc + 1;
                if (cyc < 2 * int'(nblk_in) && cyc % 2 == 0) begin
                    blk_valid_out <= 1'b1;
                    blk_err_out <= (cyc / 2 < int'(nerr_in));
                end
                if (def_in && cyc == 5) begin
                    defect_out <= 1'b1;
                end
                if (cyc == SEC - 1) begin
                    sec_tick_out <= 1'b1;
                    busy_out <= 1'b0;
                end
            end
        end
    end
endmodule

// *** sim/testbench.sv ***
`timescale 1ns/100ps
module testbench;
    import pesm_pkg::*;
    localparam int BPS = 20;
    localparam int LIMIT = 20000;
    `define CHK(a, e) begin \
        check_count++; \
        if ((a) !== (e)) begin \
            fail_count++; \
            $display("wrong value at %0t: got %h want %h", $time, a, e); \
        end \
    end
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic period_start = 1'b0;
    logic ratio_req = 1'b0;
    logic go = 1'b0;
    logic def = 1'b0;
    logic [7:0] nerr = 8'h00;
    logic blk_valid, blk_err, defect, tick, src_busy, sec_done, avail, rvalid, rbusy;
    logic [31:0] ebc, ebf;
    pesm_counts_t counts;
    pesm_sec_t cls;
    pesm_ratio_t ratio;
    int fail_count = 0;
    int check_count = 0;
    int cycles = 0;
    int k;
    pesm_sec_t q[$];
    logic av = 1'b1;
    logic [31:0] c_err, c_sev, c_bkg, c_unav, c_p;

    always #2.5 clk = ~clk;

    pesm_src u_src (.ref_clk_in(clk), .rst_in(rst), .go_in(go), .nblk_in(8'(BPS)),
        .nerr_in(nerr), .def_in(def), .blk_valid_out(blk_valid), .blk_err_out(blk_err),
        .defect_out(defect), .sec_tick_out(tick), .busy_out(src_busy));
    pesm_monitor #(.BPS(BPS)) uut (.ref_clk_in(clk), .rst_in(rst), .sec_tick_in(tick),
        .period_start_in(period_start), .blk_valid_in(blk_valid), .blk_err_in(blk_err),
        .defect_in(defect), .ratio_req_in(ratio_req), .counts_out(counts),
        .errored_block_count_out(ebc), .errored_block_fraction_out(ebf),
        .sec_done_out(sec_done), .sec_class_out(cls), .available_out(avail),
        .ratio_out(ratio), .ratio_valid_out(rvalid), .ratio_busy_out(rbusy));

    // ------------------------------------------------------------
    // Reference model
    // ------------------------------------------------------------
    function automatic pesm_sec_t classify(int ne, logic df);
        classify.errored_second = df || ne > 0;
        classify.severe_error_second = df || ne * PCT_DEN >= BPS * SEVERE_PCT;
        classify.background_block_error = classify.severe_error_second ? '0 : 32'(ne);
    endfunction
    // Q16.16 quotient; a zero divisor saturates
    function automatic logic [31:0] qdiv(logic [31:0] n, logic [63:0] d);
        return (d == 0) ? 32'hffff_ffff : 32'((64'(n) << FRAC_W) / d);
    endfunction

    task automatic summarize();
        if (fail_count == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // One second from the source; the oldest lagged second is tallied under the old state
    task automatic run_sec(int ne, logic df);
        pesm_sec_t s;
        pesm_sec_t o;
        int i;
        int n;
        s = classify(ne, df);
        nerr <= 8'(ne);
        def <= df;
        go <= 1'b1;
        @(negedge clk);
        go <= 1'b0;
        @(negedge clk);
        i = 0;
        while (src_busy && i < 200) begin
            @(negedge clk);
            i++;
        end
        `CHK(sec_done, 1'b1)
        `CHK(cls, s)
        `CHK(ebc, 32'(ne))
        q.push_back(s);
        if (q.size() > LAG_S) begin
            o = q.pop_front();
            c_p++;
            c_unav += 32'(!av);
            c_err += 32'(av & o.errored_second);
            c_sev += 32'(av & o.severe_error_second);
            c_bkg += av ? o.background_block_error : 32'h0000_0000;
        end
        n = 0;
        foreach (q[j]) n += int'(q[j].severe_error_second);
        av = (q.size() == LAG_S && n == LAG_S) ? 1'b0 : av;
        av = (q.size() == LAG_S && n == 0) ? 1'b1 : av;
        repeat (70) @(negedge clk);
        `CHK(ebf, qdiv(32'(ne), 64'(BPS)))
        `CHK(avail, av)
        `CHK(counts, {c_err, c_sev, c_bkg, c_unav, c_p})
    endtask

    task automatic ratio_chk();
        int i;
        logic [31:0] a;
        pesm_ratio_t r;
        a = c_p - c_unav;
        r = {qdiv(c_bkg, 64'(a - c_sev) * BPS), qdiv(c_err, 64'(a)), qdiv(c_sev, 64'(a))};
        ratio_req <= 1'b1;
        @(negedge clk);
        ratio_req <= 1'b0;
        i = 0;
        while (!rvalid && i < 100) begin
            @(negedge clk);
            i++;
        end
        `CHK(rvalid, 1'b1)
        `CHK(ratio, r)
        repeat (2) @(negedge clk);
    endtask

    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            fail_count++;
            summarize();
        end
    end

    // Corners, random seconds, an outage and recovery, then a new period
    initial begin
        {c_err, c_sev, c_bkg, c_unav, c_p} = '0;
        void'($urandom(32'h73381ab7));
        repeat (4) @(posedge clk);
        @(negedge clk);
        rst <= 1'b0;
        @(negedge clk);
        `CHK(counts, '0)
        `CHK(avail, 1'b1)
        run_sec(5, 1'b0);
        run_sec(6, 1'b0);
        run_sec(0, 1'b1);
        run_sec(0, 1'b0);
        for (k = 0; k < 12; k++) run_sec($urandom_range(8), $urandom_range(9) == 0);
        ratio_chk();
        for (k = 0; k < 14; k++) run_sec(k % 3 * 7, 1'b1);
        ratio_chk();
        for (k = 0; k < 13; k++) run_sec($urandom_range(5), 1'b0);
        ratio_chk();
        period_start <= 1'b1;
        @(negedge clk);
        period_start <= 1'b0;
        {c_err, c_sev, c_bkg, c_unav, c_p} = '0;
        @(negedge clk);
        `CHK(counts, '0)
        ratio_chk();
        for (k = 0; k < 12; k++) run_sec($urandom_range(8), $urandom_range(5) == 0);
        ratio_chk();
        summarize();
    end
endmodule
